// *** rtl/ism_pkg.sv ***
// Constants and types for the interrupt source mask block
package ism_pkg;
   // Register offsets on the management bus
   localparam logic [7:0] REG_ANALOG_MASK_B = 8'h19;
   localparam logic [7:0] REG_TACH_MASK = 8'h1a;
   localparam logic [7:0] REG_MISC_MASK = 8'h1b;
   // Mask value after reset and read value of unmapped offsets
   localparam logic [7:0] MASK_RESET = 8'h00;
   localparam logic [7:0] RDATA_UNMAPPED = 8'h00;
   // Writable bits of the misc mask; bit 5 has no function
   localparam logic [7:0] MISC_WRITE_MASK = 8'hdf;
   // Field positions in the misc mask
   localparam int MISC_INT_TEMP = 0;
   localparam int MISC_BATTERY = 1;
   localparam int MISC_ANALOG_8 = 2;
   localparam int MISC_OVERTEMP = 3;
   localparam int MISC_AUTO_COOL = 4;
   localparam int MISC_UNUSED = 5;
   localparam int MISC_INTRUSION = 6;
   localparam int MISC_GENERAL_IO_16 = 7;
   // Lowest analog input held in the upper part of mask B
   localparam int ANALOG_FIRST = 3;
   // Bus slave address, arbitrary value
   localparam logic [6:0] DEV_ADDR = 7'h30;
   // Bits in one bus byte
   localparam logic [3:0] BYTE_BITS = 4'h8;
   // Bus slave states
   typedef enum logic [3:0] {
      ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_CMD, ST_CMD_ACK,
      ST_WDATA, ST_WDATA_ACK, ST_RDATA, ST_RDATA_ACK
   } ism_state_e;
endpackage

// *** rtl/ism_line.sv ***
// Bus line synchroniser with edge, start and stop detection
`timescale 1ns/1ps
module ism_line (
   input wire logic clk, // System clock
   input wire logic sys_rst, // Synchronous reset
   input wire logic scl_in, // Bus clock pin level
   input wire logic sda_in, // Bus data pin level
   output logic sda_level, // Synchronised data level
   output logic scl_rise, // Bus clock rising edge
   output logic scl_fall, // Bus clock falling edge
   output logic start_det, // Start or repeated start
   output logic stop_det // Stop condition
);
   logic [2:0] scl_q, scl_d;
   logic [2:0] sda_q, sda_d;

   // Two synchroniser stages plus one history stage
   always_comb begin
      scl_d = {scl_q[1:0], scl_in};
      sda_d = {sda_q[1:0], sda_in};
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         scl_q <= 3'h7;
         sda_q <= 3'h7;
      end else begin
         scl_q <= scl_d;
         sda_q <= sda_d;
      end
   end

   // Only stages 1 and 2 feed the decode
   assign sda_level = sda_q[1];
   assign scl_rise = scl_q[1] & ~scl_q[2];
   assign scl_fall = ~scl_q[1] & scl_q[2];
   assign start_det = scl_q[1] & scl_q[2] & ~sda_q[1] & sda_q[2];
   assign stop_det = scl_q[1] & scl_q[2] & sda_q[1] & ~sda_q[2];
endmodule // ism_line

// *** rtl/ism_masks.sv ***
// Interrupt source masks with two-wire bus register access
//
// Contract
// - Mask B bits 3 to 7 block analog inputs 3 to 7 while set.
// - The mask at 1Ah blocks tach channel n by bit n while set.
// - The tach mask and the misc mask reset to all zero.
// - Misc bit 0 blocks the internal temperature channel.
// - Misc bit 1 blocks the battery voltage channel.
// - Misc bit 2 blocks analog input 8.
// - Misc bit 3 blocks overtemperature events.
// - Misc bit 4 blocks automatic cooling control events.
// - Misc bit 5 does nothing and always reads zero.
// - Misc bit 6 blocks the chassis intrusion input.
// - Misc bit 7 blocks general I/O line 16.
`timescale 1ns/1ps
module ism_masks (
   input wire logic clk, // System clock, 200 MHz
   input wire logic sys_rst, // Synchronous reset, active high
   input wire logic scl_in, // Bus clock pin
   input wire logic sda_in, // Bus data pin level
   output logic sda_o, // Bus data drive value
   output logic sda_oe, // Bus data drive enable
   input wire logic [4:0] analog_status, // Pending analog inputs 3..7
   input wire logic [7:0] tach_status, // Pending tach channels 0..7
   input wire logic [7:0] misc_status, // Pending misc sources
   output logic [4:0] analog_irq, // Unmasked analog requests
   output logic [7:0] tach_irq, // Unmasked tach requests
   output logic [7:0] misc_irq, // Unmasked misc requests
   output logic irq_any // Combined request
);
   logic sda_level;
   logic scl_rise;
   logic scl_fall;
   logic start_det;
   logic stop_det;
   ism_pkg::ism_state_e state_q, state_d;
   logic [3:0] cnt_q, cnt_d;
   logic [7:0] sh_q, sh_d;
   logic [7:0] ptr_q, ptr_d;
   logic rw_q, rw_d;
   logic oe_q, oe_d;
   logic wr_stb;
   logic [7:0] an_mask_q, an_mask_d;
   logic [7:0] tach_mask_q, tach_mask_d;
   logic [7:0] misc_mask_q, misc_mask_d;
   logic [4:0] analog_irq_q, analog_irq_d;
   logic [7:0] tach_irq_q, tach_irq_d;
   logic [7:0] misc_irq_q, misc_irq_d;
   logic irq_q, irq_d;
   logic sda_o_q;

   // Read mux for the mask registers
   function automatic logic [7:0] reg_read(input logic [7:0] addr,
         input logic [7:0] an, input logic [7:0] ta, input logic [7:0] mi);
      logic [7:0] r;
      r = ism_pkg::RDATA_UNMAPPED;
      if (addr == ism_pkg::REG_ANALOG_MASK_B) r = an;
      if (addr == ism_pkg::REG_TACH_MASK) r = ta;
      if (addr == ism_pkg::REG_MISC_MASK) r = mi & ism_pkg::MISC_WRITE_MASK;
      return r;
   endfunction

   ism_line u_line (
      .clk(clk),
      .sys_rst(sys_rst),
      .scl_in(scl_in),
      .sda_in(sda_in),
      .sda_level(sda_level),
      .scl_rise(scl_rise),
      .scl_fall(scl_fall),
      .start_det(start_det),
      .stop_det(stop_det)
   );

   // Bus slave: byte write and byte read with repeated start
   always_comb begin
      state_d = state_q;
      cnt_d = cnt_q;
      sh_d = sh_q;
      ptr_d = ptr_q;
      rw_d = rw_q;
      oe_d = oe_q;
      wr_stb = 1'b0;
      if (stop_det) begin
         state_d = ism_pkg::ST_IDLE;
         oe_d = 1'b0;
      end else if (start_det) begin
         state_d = ism_pkg::ST_ADDR;
         cnt_d = 4'h0;
         oe_d = 1'b0;
      end else begin
         unique case (state_q)
            ism_pkg::ST_IDLE: begin
               oe_d = 1'b0;
            end
            ism_pkg::ST_ADDR, ism_pkg::ST_CMD, ism_pkg::ST_WDATA: begin
               if (scl_rise && cnt_q != ism_pkg::BYTE_BITS) begin
                  sh_d = {sh_q[6:0], sda_level};
                  cnt_d = cnt_q + 4'h1;
               end else if (scl_fall && cnt_q == ism_pkg::BYTE_BITS) begin
                  cnt_d = 4'h0;
                  oe_d = 1'b1;
                  if (state_q == ism_pkg::ST_ADDR) begin
                     rw_d = sh_q[0];
                     if (sh_q[7:1] == ism_pkg::DEV_ADDR) begin
                        state_d = ism_pkg::ST_ADDR_ACK;
                     end else begin
                        oe_d = 1'b0;
                        state_d = ism_pkg::ST_IDLE;
                     end
                  end else if (state_q == ism_pkg::ST_CMD) begin
                     ptr_d = sh_q;
                     state_d = ism_pkg::ST_CMD_ACK;
                  end else begin
                     wr_stb = 1'b1;
                     state_d = ism_pkg::ST_WDATA_ACK;
                  end
               end
            end
            ism_pkg::ST_ADDR_ACK, ism_pkg::ST_CMD_ACK,
            ism_pkg::ST_WDATA_ACK: begin
               if (scl_fall) begin
                  oe_d = 1'b0;
                  cnt_d = 4'h0;
                  if (state_q != ism_pkg::ST_ADDR_ACK) begin
                     state_d = ism_pkg::ST_WDATA;
                  end else if (rw_q) begin
                     sh_d = reg_read(ptr_q, an_mask_q, tach_mask_q,
                        misc_mask_q);
                     oe_d = ~sh_d[7];
                     state_d = ism_pkg::ST_RDATA;
                  end else begin
                     state_d = ism_pkg::ST_CMD;
                  end
               end
            end
            ism_pkg::ST_RDATA: begin
               if (scl_rise && cnt_q != ism_pkg::BYTE_BITS) begin
                  cnt_d = cnt_q + 4'h1;
               end else if (scl_fall && cnt_q == ism_pkg::BYTE_BITS) begin
                  oe_d = 1'b0;
                  cnt_d = 4'h0;
                  state_d = ism_pkg::ST_RDATA_ACK;
               end else if (scl_fall) begin
                  sh_d = {sh_q[6:0], 1'b0};
                  oe_d = ~sh_d[7];
               end
            end
            ism_pkg::ST_RDATA_ACK: begin
               if (scl_rise) begin
                  cnt_d = {3'h0, sda_level}; // Nonzero means not acked
               end else if (scl_fall) begin
                  if (cnt_q == 4'h0) begin
                     sh_d = reg_read(ptr_q, an_mask_q, tach_mask_q,
                        misc_mask_q);
                     oe_d = ~sh_d[7];
                     state_d = ism_pkg::ST_RDATA;
                  end else begin
                     state_d = ism_pkg::ST_IDLE;
                  end
               end
            end
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         state_q <= ism_pkg::ST_IDLE;
         cnt_q <= 4'h0;
         sh_q <= 8'h00;
         ptr_q <= 8'h00;
         rw_q <= 1'b0;
         oe_q <= 1'b0;
         sda_o_q <= 1'b0;
      end else begin
         state_q <= state_d;
         cnt_q <= cnt_d;
         sh_q <= sh_d;
         ptr_q <= ptr_d;
         rw_q <= rw_d;
         oe_q <= oe_d;
         sda_o_q <= 1'b0; // Open drain: only ever pulls low
      end
   end

   // Mask register writes
   always_comb begin
      an_mask_d = an_mask_q;
      tach_mask_d = tach_mask_q;
      misc_mask_d = misc_mask_q;
      if (wr_stb && ptr_q == ism_pkg::REG_ANALOG_MASK_B) begin
         an_mask_d = sh_q;
      end
      if (wr_stb && ptr_q == ism_pkg::REG_TACH_MASK) begin
         tach_mask_d = sh_q;
      end
      if (wr_stb && ptr_q == ism_pkg::REG_MISC_MASK) begin
         misc_mask_d = sh_q & ism_pkg::MISC_WRITE_MASK;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         an_mask_q <= ism_pkg::MASK_RESET;
         tach_mask_q <= ism_pkg::MASK_RESET;
         misc_mask_q <= ism_pkg::MASK_RESET;
      end else begin
         an_mask_q <= an_mask_d;
         tach_mask_q <= tach_mask_d;
         misc_mask_q <= misc_mask_d;
      end
   end

   // Gating of pending status; status itself is never touched
   always_comb begin
      analog_irq_d = analog_status
         & ~an_mask_q[7:ism_pkg::ANALOG_FIRST];
      tach_irq_d = tach_status & ~tach_mask_q;
      // Bits 0-4, 6, 7 gate their sources; bit 5 has none
      misc_irq_d = misc_status & ~misc_mask_q
         & ism_pkg::MISC_WRITE_MASK;
      irq_d = |{analog_irq_d, tach_irq_d, misc_irq_d};
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         analog_irq_q <= 5'h00;
         tach_irq_q <= 8'h00;
         misc_irq_q <= 8'h00;
         irq_q <= 1'b0;
      end else begin
         analog_irq_q <= analog_irq_d;
         tach_irq_q <= tach_irq_d;
         misc_irq_q <= misc_irq_d;
         irq_q <= irq_d;
      end
   end

   assign sda_o = sda_o_q;
   assign sda_oe = oe_q;
   assign analog_irq = analog_irq_q;
   assign tach_irq = tach_irq_q;
   assign misc_irq = misc_irq_q;
   assign irq_any = irq_q;

   // Checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   sequence s_unmask_pending;
      $fell(tach_mask_q[0]) && tach_status[0];
   endsequence

   // Previous cycle ran out of reset; gated outputs are zero before that
   sequence s_running;
      !$past(sys_rst);
   endsequence

   a_analog_gate: assert property (s_running |-> analog_irq_q ==
      $past(analog_status & ~an_mask_q[7:3])) else $error("analog gating");
   a_tach_write: assert property (
      wr_stb && ptr_q == ism_pkg::REG_TACH_MASK |=>
      tach_mask_q == $past(sh_q) ##1
      tach_irq_q == $past(tach_status & ~tach_mask_q))
      else $error("tach mask write");
   a_reset_clear: assert property (@(posedge clk) disable iff (1'b0)
      sys_rst |=> tach_mask_q == 8'h00 && misc_mask_q == 8'h00)
      else $error("masks not cleared");
   a_int_temp_gate: assert property (s_running |-> misc_irq_q[0] ==
      $past(misc_status[0] & ~misc_mask_q[0])) else $error("int temp gating");
   a_battery_gate: assert property (s_running |-> misc_irq_q[1] ==
      $past(misc_status[1] & ~misc_mask_q[1])) else $error("battery gating");
   a_analog8_gate: assert property (s_running |-> misc_irq_q[2] ==
      $past(misc_status[2] & ~misc_mask_q[2])) else $error("analog 8 gating");
   a_overtemp_gate: assert property (s_running |-> misc_irq_q[3] ==
      $past(misc_status[3] & ~misc_mask_q[3])) else $error("overtemp gating");
   a_cooling_gate: assert property (s_running |-> misc_irq_q[4] ==
      $past(misc_status[4] & ~misc_mask_q[4])) else $error("cooling gating");
   a_unused_zero: assert property (!misc_mask_q[5] && !misc_irq_q[5])
      else $error("unused bit set");
   a_intrusion_gate: assert property (s_running |-> misc_irq_q[6] ==
      $past(misc_status[6] & ~misc_mask_q[6])) else $error("intrusion gating");
   a_gio16_gate: assert property (s_running |-> misc_irq_q[7] ==
      $past(misc_status[7] & ~misc_mask_q[7])) else $error("io 16 gating");
   a_unmask_release: assert property (s_unmask_pending |=>
      tach_irq_q[0] && irq_q) else $error("unmask lost event");
endmodule // ism_masks

// *** testbench/tb_top.sv ***
// Self-checking bench for the interrupt source mask block
`timescale 1ns/1ps
module tb_top;
   localparam int Q = 4; // Clocks per quarter of a bus bit
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   logic scl_pin = 1'b1;
   logic host_sda = 1'b1;
   logic sda_line;
   logic sda_o;
   logic sda_oe;
   logic [4:0] analog_status = 5'h00;
   logic [7:0] tach_status = 8'h00;
   logic [7:0] misc_status = 8'h00;
   logic [4:0] analog_irq;
   logic [7:0] tach_irq;
   logic [7:0] misc_irq;
   logic irq_any;
   logic [7:0] rd;
   logic ack;
   logic [7:0] offs [4];
   int bad_count = 0;
   int comparisons = 0;
   integer seed = 32'h1763;
   int m_b = 0; // Model of analog mask B
   int m_t = 0; // Model of tach mask
   int m_m = 0; // Model of misc mask

   // Clock and open-drain data line
   always #2.5 clk = ~clk;
   assign sda_line = host_sda & ~(sda_oe & ~sda_o);

   ism_masks u_ism_masks (
      .clk(clk), .sys_rst(sys_rst), .scl_in(scl_pin), .sda_in(sda_line),
      .sda_o(sda_o), .sda_oe(sda_oe), .analog_status(analog_status),
      .tach_status(tach_status), .misc_status(misc_status),
      .analog_irq(analog_irq), .tach_irq(tach_irq), .misc_irq(misc_irq),
      .irq_any(irq_any)
   );

   // Wait n edges, then step just past the edge
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   // Shared reporting for all compares
   task automatic note(input logic ok, input logic [7:0] got,
         input logic [7:0] exp);
      comparisons++;
      if (ok !== 1'b1) begin
         bad_count++;
         $display("FAIL %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
      note(got === exp, got, exp);
   endtask
   task automatic chk_irq(input logic [7:0] got, input logic [7:0] exp);
      note(got === exp, got, exp);
   endtask
   task automatic chk_ack(input logic got, input logic exp);
      note(got === exp, {7'h00, got}, {7'h00, exp});
   endtask

   // Bus bit and framing primitives
   task automatic bit_out(input logic b);
      host_sda = b;
      tick(Q);
      scl_pin = 1'b1;
      tick(2 * Q);
      scl_pin = 1'b0;
      tick(Q);
   endtask
   task automatic bit_in(output logic b);
      host_sda = 1'b1;
      tick(Q);
      scl_pin = 1'b1;
      tick(Q);
      b = sda_line;
      tick(Q);
      scl_pin = 1'b0;
      tick(Q);
   endtask
   task automatic start_c();
      host_sda = 1'b1;
      tick(Q);
      scl_pin = 1'b1;
      tick(Q);
      host_sda = 1'b0;
      tick(Q);
      scl_pin = 1'b0;
      tick(Q);
   endtask
   task automatic stop_c();
      host_sda = 1'b0;
      tick(Q);
      scl_pin = 1'b1;
      tick(Q);
      host_sda = 1'b1;
      tick(Q);
   endtask
   task automatic byte_out(input logic [7:0] d, input logic exp_ack);
      logic b;
      for (int i = 7; i >= 0; i--) bit_out(d[i]);
      bit_in(b);
      chk_ack(~b, exp_ack);
   endtask

   // Register write and read, with the model kept alongside
   task automatic reg_write(input logic [7:0] o, input logic [7:0] d);
      start_c();
      byte_out({ism_pkg::DEV_ADDR, 1'b0}, 1'b1);
      byte_out(o, 1'b1);
      byte_out(d, 1'b1);
      stop_c();
      if (o == ism_pkg::REG_ANALOG_MASK_B) m_b = d;
      if (o == ism_pkg::REG_TACH_MASK) m_t = d;
      if (o == ism_pkg::REG_MISC_MASK) m_m = d & 8'hdf;
   endtask
   task automatic reg_read(input logic [7:0] o, output logic [7:0] d);
      start_c();
      byte_out({ism_pkg::DEV_ADDR, 1'b0}, 1'b1);
      byte_out(o, 1'b1);
      start_c();
      byte_out({ism_pkg::DEV_ADDR, 1'b1}, 1'b1);
      for (int i = 7; i >= 0; i--) bit_in(d[i]);
      bit_out(1'b1);
      stop_c();
   endtask
   function automatic logic [7:0] exp_reg(input logic [7:0] o);
      if (o == ism_pkg::REG_ANALOG_MASK_B) return m_b[7:0];
      if (o == ism_pkg::REG_TACH_MASK) return m_t[7:0];
      if (o == ism_pkg::REG_MISC_MASK) return m_m[7:0];
      return 8'h00;
   endfunction

   // Read back every mask and one unmapped place
   task automatic read_all();
      for (int k = 0; k < 4; k++) begin
         reg_read(offs[k], rd);
         chk_reg(rd, exp_reg(offs[k]));
      end
   endtask

   // Gated request outputs against the model
   task automatic check_irqs();
      logic [7:0] ea, et, em;
      tick(2);
      ea = {3'h0, analog_status & ~m_b[7:3]};
      et = tach_status & ~m_t[7:0];
      em = misc_status & ~m_m[7:0] & 8'hdf;
      chk_irq({3'h0, analog_irq}, ea);
      chk_irq(tach_irq, et);
      chk_irq(misc_irq, em);
      chk_irq({7'h00, irq_any}, {7'h00, |{ea, et, em}});
   endtask

   // Counts, verdict and end of run
   task automatic end_sim();
      $display("Comparisons %0d, mismatches %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   // Watchdog against a hung run
   initial begin
      repeat (100000) @(posedge clk);
      bad_count++;
      end_sim();
   end

   // Main sequence
   initial begin
      offs = '{ism_pkg::REG_ANALOG_MASK_B, ism_pkg::REG_TACH_MASK,
         ism_pkg::REG_MISC_MASK, 8'h20};
      tick(10);
      sys_rst = 1'b0;
      tick(4);
      read_all();
      // Foreign address is left unanswered
      start_c();
      byte_out(8'h62, 1'b0);
      stop_c();
      // All pending while fully masked, then released
      {analog_status, tach_status, misc_status} = 21'h1fffff;
      for (int k = 0; k < 4; k++) reg_write(offs[k], 8'hff);
      check_irqs();
      read_all();
      for (int k = 0; k < 3; k++) reg_write(offs[k], 8'h00);
      check_irqs();
      // Random masks and status
      repeat (10) begin
         {analog_status, tach_status, misc_status} = 21'($random(seed));
         check_irqs();
         for (int k = 0; k < 3; k++) reg_write(offs[k], 8'($random(seed)));
         check_irqs();
         read_all();
      end
      // Second reset in mid-run clears the masks
      sys_rst = 1'b1;
      tick(3);
      sys_rst = 1'b0;
      m_b = 0;
      m_t = 0;
      m_m = 0;
      tick(4);
      check_irqs();
      read_all();
      end_sim();
   end
endmodule // tb_top
